// File: bench/scc_sync_src.sv
// Purpose: video source model for sync, clamp, coast pins
// Assumes: order {coast, clamp, sep, vs, sog, hs}
// Notes: running pins toggle at distinct rates
`timescale 1ns/100ps
module scc_sync_src (
	input wire logic clk,
	input wire logic [5:0] run,
	input wire logic [5:0] lvl,
	output logic [5:0] pins
);
	logic [6:0] cnt = 7'h00;
	initial pins = 6'h00;
	always @(negedge clk)
	begin
		cnt <= cnt + 7'h01;
		for (int i = 0; i < 6; i++)
			pins[i] <= run[i] ? cnt[i + 1] : lvl[i];
	end
endmodule

// File: bench/scc_top_props.sv
// Purpose: port checks for scc_top
// Assumes: CE held high
// Notes: pin paths take three clocks
`timescale 1ns/100ps
module scc_top_props #(
	parameter int ACT_TIMEOUT = scc_pkg::ACT_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic SCL_IN,
	input wire logic SDA_OE,
	input wire logic HSYNC_IN,
	input wire logic SOG_IN,
	input wire logic VSYNC_IN,
	input wire logic HSYNC_OUT,
	input wire logic VSYNC_OUT,
	input wire logic PLL_HSYNC_OUT,
	input wire logic COAST_OUT,
	input wire logic CLAMP_OUT,
	input wire logic SEEK_MODE_OUT,
	input wire logic PWR_NORMAL_OUT
);
	logic [1:0] age_q;
	logic [15:0] quiet_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// sync flops hold reset values for three edges
	always_ff @(posedge CLK)
		age_q <= !RESETN ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
	always_ff @(posedge CLK)
		quiet_q <= !RESETN ? 16'hFFFF : $changed({HSYNC_IN, SOG_IN, VSYNC_IN}) ? 16'h0000
			: quiet_q + {15'h0000, quiet_q != 16'hFFFF};
	a_reset_values:
	assert property ($rose(RESETN) |-> !HSYNC_OUT && VSYNC_OUT && !PLL_HSYNC_OUT && !COAST_OUT
		&& !CLAMP_OUT && !SEEK_MODE_OUT && PWR_NORMAL_OUT && !SDA_OE) else $error("bad reset outputs");
	a_coast_gate:
	assert property (PLL_HSYNC_OUT |-> !COAST_OUT) else $error("hsync passed in coast");
	a_pll_source:
	assert property (age_q == 2'h3 && !COAST_OUT && $past(HSYNC_IN, 3) == $past(SOG_IN, 3)
		|-> PLL_HSYNC_OUT == $past(HSYNC_IN, 3)) else $error("pll hsync source wrong");
	a_seek_wake_hs:
	assert property (age_q == 2'h3 && $changed(HSYNC_IN) |-> ##[1:8] !SEEK_MODE_OUT) else $error("seek on hs");
	a_seek_wake_sog:
	assert property (age_q == 2'h3 && $changed(SOG_IN) |-> ##[1:8] !SEEK_MODE_OUT) else $error("seek on sog");
	a_seek_wake_vs:
	assert property (age_q == 2'h3 && $changed(VSYNC_IN) |-> ##[1:8] !SEEK_MODE_OUT) else $error("seek on vs");
	a_seek_rise_quiet:
	assert property ($rose(SEEK_MODE_OUT) |-> quiet_q >= ACT_TIMEOUT) else $error("seek too early");
	a_sda_scl_low:
	assert property (age_q == 2'h3 && $changed(SDA_OE) |-> !$past(SCL_IN, 2)) else $error("sda moved, scl high");
endmodule
bind scc_top scc_top_props #(.ACT_TIMEOUT(ACT_TIMEOUT)) props_i (.*);

// File: bench/tb_scc_top.sv
// Purpose: register and pin tests for scc_top
// Assumes: activity timeout shortened to 20
// Notes: serial master drives on falling edges
`timescale 1ns/100ps
module tb_scc_top;
	logic clk = 0;
	logic resetn = 0;
	logic scl = 1;
	logic sdam = 1;
	logic int_clamp = 0;
	logic c;
	logic [5:0] run = 6'h00;
	logic [5:0] lvl = 6'h00;
	logic [5:0] pins;
	logic sda_oe, sda_o, hs_o, vs_o, pll_o, coast_o, clamp_o, seek_o, pwr_o;
	logic [7:0] v;
	logic [5:0] rm [6] = '{6'h01, 6'h02, 6'h05, 6'h03, 6'h03, 6'h00};
	logic [7:0] ex [6] = '{8'h80, 8'h4A, 8'h90, 8'h8A, 8'hCA, 8'h00};
	int err_count = 0;
	int checks = 0;
	// open drain: released wire reads high
	wire sda = sdam & !(sda_oe & !sda_o);
	always #20 clk = ~clk;
	scc_sync_src src (.clk(clk), .run(run), .lvl(lvl), .pins(pins));
	scc_top #(.ACT_TIMEOUT(20)) dut (.CLK(clk), .RESETN(resetn), .CE(1'b1), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_o), .SDA_OE(sda_oe), .HSYNC_IN(pins[0]), .SOG_IN(pins[1]), .VSYNC_IN(pins[2]),
		.SEP_VSYNC_IN(pins[3]), .CLAMP_IN(pins[4]), .COAST_IN(pins[5]), .INT_CLAMP_IN(int_clamp),
		.HSYNC_OUT(hs_o), .VSYNC_OUT(vs_o), .PLL_HSYNC_OUT(pll_o), .COAST_OUT(coast_o),
		.CLAMP_OUT(clamp_o), .SEEK_MODE_OUT(seek_o), .PWR_NORMAL_OUT(pwr_o));
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task tdone(input int n);
		$display("test %0d done", n);
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task bitx(input logic b, output logic r);
		w(3);
		sdam = b;
		w(4);
		scl = 1;
		w(6);
		r = sda;
		scl = 0;
	endtask
	task xb(input logic [7:0] d, input logic k, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(1'b1, a);
		if (k)
			chk({7'h00, a}, 8'h00);
	endtask
	task st;
		w(3);
		sdam = 1;
		w(4);
		scl = 1;
		w(6);
		sdam = 0;
		w(6);
		scl = 0;
	endtask
	task sp;
		w(3);
		sdam = 0;
		w(4);
		scl = 1;
		w(6);
		sdam = 1;
		w(6);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		st;
		xb({scc_pkg::SERIAL_ADDR, 1'b0}, 1'b1, q);
		xb(a, 1'b1, q);
		xb(d, 1'b1, q);
		sp;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		st;
		xb({scc_pkg::SERIAL_ADDR, 1'b0}, 1'b1, d);
		xb(a, 1'b1, d);
		st;
		xb({scc_pkg::SERIAL_ADDR, 1'b1}, 1'b1, d);
		xb(8'hFF, 1'b0, d);
		sp;
	endtask
	initial
	begin
		repeat (95000) @(posedge clk);
		err_count++;
		end_of_test;
	end
	initial
	begin
		w(10);
		resetn = 1;
		w(3);
		rd(8'h0E, v);
		chk(v, 8'h40);
		rd(8'h0F, v);
		chk(v, 8'h4E);
		rd(8'h20, v);
		chk(v, 8'h00);
		tdone(1);
		lvl = 6'h05;
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h0E, 8'h52 | {2'b00, i[3], 1'b0, i[2], i[1], 1'b0, i[0]});
			w(8);
			chk({5'h00, hs_o, vs_o, pll_o}, {5'h00, lvl[i[2]] ^ i[3], lvl[{1'b1, i[0]}] ^ !i[1], lvl[i[2]]});
		end
		tdone(2);
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h0E, (i == 4) ? 8'h48 : 8'h40);
			run = rm[i];
			lvl = 6'h00;
			w(60);
			rd(8'h14, v);
			chk(v & 8'hDA, ex[i]);
		end
		chk({7'h00, seek_o}, 8'h01);
		wr(8'h0F, 8'h4A);
		w(8);
		chk({7'h00, seek_o}, 8'h00);
		chk({7'h00, pwr_o}, 8'h01);
		tdone(3);
		for (int i = 0; i < 16; i++)
		begin
			int_clamp = i[0];
			lvl = {1'b0, i[1], 4'h0};
			wr(8'h0F, {i[3], i[2], 6'h0A});
			w(8);
			chk({7'h00, clamp_o}, {7'h00, i[3] ? i[1] ^ i[2] : i[0]});
		end
		// coast pin low since reset, so automatic polarity is active high
		wr(8'h0F, 8'h40);
		w(8);
		chk({7'h00, coast_o}, 8'h00);
		chk({7'h00, pwr_o}, 8'h00);
		rd(8'h0F, v);
		chk(v, 8'h40);
		tdone(4);
		wr(8'h0E, 8'h52);
		for (int i = 0; i < 16; i++)
		begin
			lvl = {i[1], 2'b00, i[0], 2'b01};
			wr(8'h0F, {2'b01, i[3], 1'b1, i[2], 3'b010});
			w(8);
			c = (i[3] ? i[0] : i[1]) ~^ i[2];
			chk({6'h00, coast_o, pll_o}, {6'h00, c, !c});
		end
		tdone(5);
		end_of_test;
	end
endmodule

// File: verilog/scc_activity_det.sv
// Purpose: reports whether a synchronised sync input is toggling
// Assumes: input already passed a two-stage synchroniser
// Notes: activity times out after TIMEOUT_CYC + 1 cycles with no edge
`timescale 1ns/100ps
module scc_activity_det #(
	parameter int TIMEOUT_CYC = scc_pkg::ACT_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic sig,
	output logic active
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYC);

	logic prev_q;
	logic [CW-1:0] idle_cnt_q;

	if (TIMEOUT_CYC < 1)
	begin : g_bad_timeout
		$error("scc_activity_det: TIMEOUT_CYC must be at least 1");
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			// same level as the synchroniser reset, so release shows no false edge
			prev_q <= 1'b1;
			idle_cnt_q <= '0;
			active <= 1'b0;
		end
		else if (ce)
		begin
			prev_q <= sig;
			if (sig != prev_q)
			begin
				idle_cnt_q <= '0;
				active <= 1'b1;
			end
			else if (idle_cnt_q == LIMIT)
				active <= 1'b0; // see R18
			else
				idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end
endmodule

// File: verilog/scc_pkg.sv
// Purpose: shared constants and types for the sync, clamp and coast source selection block
// Assumes: pixel clock CLK at 25 MHz; registers reached over the 2-wire serial port
// Notes:
// Functional notes
// R1: hsync output polarity bit 0 positive, 1 negative
// R2: hsync override uses select bit, else auto status
// R3: hsync select 0 dedicated pin, 1 sync-on-green
// R4: both hsync candidates active: select bit decides
// R5: vsync invert bit 0 inverts, 1 passes
// R6: vsync override uses select bit, else auto status
// R7: vsync select 0 input pin, 1 separator
// R8: clamp source 0 internal timing, 1 external pin
// R9: external clamp clamps all three channels while active
// R10: clamp polarity 1 clamps on low pin
// R11: coast source 0 coast pin, 1 active vsync
// R12: coast polarity override 0 automatic, 1 user bit
// R13: coast asserted gates hsync from clock generator
// R14: user coast polarity only applies with override
// R15: seek enable enters seek when no sync activity
// R16: auto hsync status 1 means sync-on-green
// R17: auto vsync status 1 means separator used
// R18: constant-level sync input reports no activity
package scc_pkg;
	localparam logic [7:0] SYNC_CONTROL_OFS = 8'h0E;
	localparam logic [7:0] INPUT_CONTROL_OFS = 8'h0F;
	localparam logic [7:0] SYNC_STATUS_OFS = 8'h14;
	localparam logic [7:0] SYNC_CONTROL_RST = 8'h40;
	localparam logic [7:0] INPUT_CONTROL_RST = 8'h4E;
	// serial port address; value is arbitrary
	localparam logic [6:0] SERIAL_ADDR = 7'h4C;
	localparam int STAT_HS_DET_BIT = 7;
	localparam int STAT_AHS_BIT = 6;
	localparam int STAT_VS_DET_BIT = 4;
	localparam int STAT_AVS_BIT = 3;
	localparam int STAT_SOG_DET_BIT = 1;
	localparam int CLK_HZ = 25000000;
	localparam int ACT_TIMEOUT_US = 100;
	localparam int ACT_TIMEOUT_CYC = (ACT_TIMEOUT_US * (CLK_HZ / 1000000));
	localparam int POL_CNT_W = 12;

	typedef struct packed {
		logic hs_in_pol_ovr;
		logic hs_in_pol;
		logic hs_out_neg;
		logic hs_ovr;
		logic hs_sel_sog;
		logic vs_no_invert;
		logic vs_ovr;
		logic vs_sel_sep;
	} scc_sync_ctrl_t;

	typedef struct packed {
		logic clamp_ext;
		logic clamp_act_low;
		logic coast_from_vs;
		logic coast_pol_ovr;
		logic coast_act_high;
		logic seek_en;
		logic pwr_normal;
		logic spare;
	} scc_input_ctrl_t;

	typedef struct packed {
		logic hs_det;
		logic sog_det;
		logic vs_det;
	} scc_activity_t;
endpackage

// File: verilog/scc_top.sv
// Purpose: sync source selection, output polarity, clamp and coast source selection, seek mode
// Assumes: pin inputs are asynchronous; INT_CLAMP_IN comes from CLK-domain clamp counters
// Notes: registers reached over the 2-wire serial port, subaddress auto-increments
`timescale 1ns/100ps
module scc_top #(
	parameter logic [6:0] DEV_ADDR = scc_pkg::SERIAL_ADDR,
	parameter int ACT_TIMEOUT = scc_pkg::ACT_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic HSYNC_IN,
	input wire logic SOG_IN,
	input wire logic VSYNC_IN,
	input wire logic SEP_VSYNC_IN,
	input wire logic CLAMP_IN,
	input wire logic COAST_IN,
	input wire logic INT_CLAMP_IN,
	output logic HSYNC_OUT,
	output logic VSYNC_OUT,
	output logic PLL_HSYNC_OUT,
	output logic COAST_OUT,
	output logic CLAMP_OUT,
	output logic SEEK_MODE_OUT,
	output logic PWR_NORMAL_OUT
);
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_SUB = 9'h008,
		ST_SUB_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} scc_state_t;

	if (ACT_TIMEOUT < 1)
	begin : g_bad_timeout
		$error("scc_top: ACT_TIMEOUT must be at least 1");
	end

	// two-stage synchronisers for every pin
	localparam int NPIN = 8;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_m_q;
	logic [NPIN-1:0] pin_s_q;
	assign pin_raw = {SCL_IN, SDA_IN, HSYNC_IN, SOG_IN, VSYNC_IN, SEP_VSYNC_IN, CLAMP_IN, COAST_IN};

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			pin_m_q <= {NPIN{1'b1}};
			pin_s_q <= {NPIN{1'b1}};
		end
		else if (CE)
		begin
			pin_m_q <= pin_raw;
			pin_s_q <= pin_m_q;
		end
	end

	logic scl_s, sda_s, hs_s, sog_s, vs_s, sep_s, clamp_s, coast_s;
	assign {scl_s, sda_s, hs_s, sog_s, vs_s, sep_s, clamp_s, coast_s} = pin_s_q;

	// serial port edge and condition detection
	logic scl_d_q;
	logic sda_d_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end
		else if (CE)
		begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign bus_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;

	scc_state_t state_q;
	logic [7:0] shreg_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] sub_q;
	logic sda_oe_q;
	logic [7:0] rd_data;
	logic wr_en;

	scc_pkg::scc_sync_ctrl_t sync_ctrl_q;
	scc_pkg::scc_input_ctrl_t input_ctrl_q;
	scc_pkg::scc_activity_t act;
	logic auto_hsync_source;
	logic auto_vsync_source;

	always_comb
	begin
		rd_data = 8'h00;
		unique case (sub_q)
			scc_pkg::SYNC_CONTROL_OFS: rd_data = sync_ctrl_q;
			scc_pkg::INPUT_CONTROL_OFS: rd_data = input_ctrl_q;
			scc_pkg::SYNC_STATUS_OFS:
			begin
				rd_data[scc_pkg::STAT_HS_DET_BIT] = act.hs_det;
				rd_data[scc_pkg::STAT_AHS_BIT] = auto_hsync_source;
				rd_data[scc_pkg::STAT_VS_DET_BIT] = act.vs_det;
				rd_data[scc_pkg::STAT_AVS_BIT] = auto_vsync_source;
				rd_data[scc_pkg::STAT_SOG_DET_BIT] = act.sog_det;
			end
			default: rd_data = 8'h00;
		endcase
	end

	assign wr_en = (state_q == ST_WDATA) && scl_fall && (bit_cnt_q == 4'h8);

	// serial port slave sequencing
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			state_q <= ST_IDLE;
			shreg_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			sub_q <= 8'h00;
			sda_oe_q <= 1'b0;
		end
		else if (CE)
		begin
			if (bus_start)
			begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end
			else if (bus_stop)
			begin
				state_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end
			else
			begin
				unique case (state_q)
					ST_IDLE:
					begin
						sda_oe_q <= 1'b0;
					end
					ST_ADDR, ST_SUB, ST_WDATA:
					begin
						if (scl_rise && bit_cnt_q != 4'h8)
						begin
							shreg_q <= {shreg_q[6:0], sda_s};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
						else if (scl_fall && bit_cnt_q == 4'h8)
						begin
							bit_cnt_q <= 4'h0;
							sda_oe_q <= 1'b1;
							if (state_q == ST_ADDR)
							begin
								if (shreg_q[7:1] == DEV_ADDR)
									state_q <= ST_ADDR_ACK;
								else
								begin
									state_q <= ST_IDLE;
									sda_oe_q <= 1'b0;
								end
							end
							else if (state_q == ST_SUB)
							begin
								sub_q <= shreg_q;
								state_q <= ST_SUB_ACK;
							end
							else
							begin
								sub_q <= sub_q + 8'h01;
								state_q <= ST_WDATA_ACK;
							end
						end
					end
					ST_ADDR_ACK:
					begin
						if (scl_fall)
						begin
							if (shreg_q[0])
							begin
								// read: first data bit goes out on the ack release edge
								shreg_q <= rd_data;
								sda_oe_q <= ~rd_data[7];
								state_q <= ST_RDATA;
							end
							else
							begin
								sda_oe_q <= 1'b0;
								state_q <= ST_SUB;
							end
						end
					end
					ST_SUB_ACK, ST_WDATA_ACK:
					begin
						if (scl_fall)
						begin
							sda_oe_q <= 1'b0;
							state_q <= ST_WDATA;
						end
					end
					ST_RDATA:
					begin
						if (scl_rise)
							bit_cnt_q <= bit_cnt_q + 4'h1;
						else if (scl_fall)
						begin
							if (bit_cnt_q == 4'h8)
							begin
								bit_cnt_q <= 4'h0;
								sda_oe_q <= 1'b0;
								state_q <= ST_RDATA_ACK;
							end
							else
							begin
								shreg_q <= {shreg_q[6:0], 1'b0};
								sda_oe_q <= ~shreg_q[6];
							end
						end
					end
					ST_RDATA_ACK:
					begin
						if (scl_rise)
						begin
							if (sda_s)
								state_q <= ST_IDLE;
							else
								sub_q <= sub_q + 8'h01;
						end
						else if (scl_fall)
						begin
							shreg_q <= rd_data;
							sda_oe_q <= ~rd_data[7];
							state_q <= ST_RDATA;
						end
					end
				endcase
			end
		end
	end

	// control registers
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			sync_ctrl_q <= scc_pkg::SYNC_CONTROL_RST;
			input_ctrl_q <= scc_pkg::INPUT_CONTROL_RST;
		end
		else if (CE && wr_en)
		begin
			if (sub_q == scc_pkg::SYNC_CONTROL_OFS)
				sync_ctrl_q <= shreg_q;
			if (sub_q == scc_pkg::INPUT_CONTROL_OFS)
				input_ctrl_q <= shreg_q;
		end
	end

	// activity detection on hsync, sync-on-green and vsync; none on the separator
	logic [2:0] det_in;
	logic [2:0] det_out;
	assign det_in = {hs_s, sog_s, vs_s};
	assign act = det_out;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_det
			scc_activity_det #(
				.TIMEOUT_CYC(ACT_TIMEOUT)
			) u_det (
				.clk(CLK),
				.resetn(RESETN),
				.ce(CE),
				.sig(det_in[gi]),
				.active(det_out[gi]) // see R18
			);
		end
	endgenerate

	// source selection
	always_comb
	begin
		if (sync_ctrl_q.hs_ovr)
			auto_hsync_source = sync_ctrl_q.hs_sel_sog; // see R2, R3
		else if (act.hs_det != act.sog_det)
			auto_hsync_source = act.sog_det; // see R16
		else
			auto_hsync_source = sync_ctrl_q.hs_sel_sog; // see R4
	end

	always_comb
	begin
		if (sync_ctrl_q.vs_ovr)
			auto_vsync_source = sync_ctrl_q.vs_sel_sep; // see R6, R7
		else if (act.vs_det != act.sog_det)
			auto_vsync_source = act.sog_det; // see R17
		else
			auto_vsync_source = sync_ctrl_q.vs_sel_sep;
	end

	logic act_hs, act_vs, coast_src;
	assign act_hs = auto_hsync_source ? sog_s : hs_s; // see R2
	assign act_vs = auto_vsync_source ? sep_s : vs_s; // see R6
	assign coast_src = input_ctrl_q.coast_from_vs ? act_vs : coast_s; // see R11

	// automatic coast polarity: the rarer level is taken as the asserted one
	logic signed [scc_pkg::POL_CNT_W-1:0] pol_cnt_q;
	localparam logic signed [scc_pkg::POL_CNT_W-1:0] POL_MAX = {1'b0, {(scc_pkg::POL_CNT_W-1){1'b1}}};
	localparam logic signed [scc_pkg::POL_CNT_W-1:0] POL_MIN = {1'b1, {(scc_pkg::POL_CNT_W-1){1'b0}}};
	// full-width step: a one-bit signed one would read as minus one
	localparam logic signed [scc_pkg::POL_CNT_W-1:0] POL_ONE = {{(scc_pkg::POL_CNT_W-1){1'b0}}, 1'b1};

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			pol_cnt_q <= '0;
		else if (CE)
		begin
			if (coast_src && pol_cnt_q != POL_MAX)
				pol_cnt_q <= pol_cnt_q + POL_ONE;
			else if (!coast_src && pol_cnt_q != POL_MIN)
				pol_cnt_q <= pol_cnt_q - POL_ONE;
		end
	end

	logic coast_level, coast_active, ext_clamp;
	// ties go to active high, the reset default
	assign coast_level = input_ctrl_q.coast_pol_ovr ? input_ctrl_q.coast_act_high : (pol_cnt_q <= 0); // see R12, R14
	assign coast_active = (coast_src == coast_level); // see R13
	assign ext_clamp = input_ctrl_q.clamp_act_low ? ~clamp_s : clamp_s; // see R10

	// registered outputs
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			HSYNC_OUT <= 1'b0;
			VSYNC_OUT <= 1'b1;
			PLL_HSYNC_OUT <= 1'b0;
			COAST_OUT <= 1'b0;
			CLAMP_OUT <= 1'b0;
			SEEK_MODE_OUT <= 1'b0;
			PWR_NORMAL_OUT <= 1'b1;
			SDA_OUT <= 1'b0;
			SDA_OE <= 1'b0;
		end
		else if (CE)
		begin
			HSYNC_OUT <= act_hs ^ sync_ctrl_q.hs_out_neg; // see R1
			VSYNC_OUT <= act_vs ^ ~sync_ctrl_q.vs_no_invert; // see R5
			// hsync held low to the clock generator while coasting
			PLL_HSYNC_OUT <= act_hs & ~coast_active; // see R13
			COAST_OUT <= coast_active; // see R13
			// one clamp strobe serves all three channels
			CLAMP_OUT <= input_ctrl_q.clamp_ext ? ext_clamp : INT_CLAMP_IN; // see R8, R9
			SEEK_MODE_OUT <= input_ctrl_q.seek_en & ~(act.hs_det | act.sog_det | act.vs_det); // see R15
			PWR_NORMAL_OUT <= input_ctrl_q.pwr_normal;
			SDA_OUT <= 1'b0;
			SDA_OE <= sda_oe_q;
		end
	end
endmodule
